// ---- logic/cafm_pkg.sv ----
// Constants for the acceptance filter match block
//
// Contract
// - Filters 12 to 15 each hold a four-bit receive buffer pointer.
// - Each filter holds an 11-bit standard identifier; compared bits must be equal.
// - With mask type qualifier set, type select picks extended or standard messages.
// - With mask type qualifier clear, the filter type select is ignored.
// - Top two extended identifier bits sit in bits 1:0 of standard register.
// - Lower sixteen extended identifier bits sit in their own register and must match.
// - Standard register bits 4 and 2 are unimplemented and read zero.
// - Sixteen filters, each with standard and extended identifier registers.
// - Filters 0 to 7 have two-bit mask source fields, filter 7 on top.
// - Each filter has an enable bit; a disabled filter never hits.
package cafm_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;

	// Word addresses on the register port
	localparam logic [5:0] OFF_SID_BASE     = 6'h00;
	localparam logic [5:0] OFF_EID_BASE     = 6'h10;
	localparam logic [5:0] OFF_BUF_PTR      = 6'h20;
	localparam logic [5:0] OFF_MSK_SEL      = 6'h21;
	localparam logic [5:0] OFF_FILT_EN      = 6'h22;
	localparam logic [5:0] OFF_HIT_STAT     = 6'h23;
	localparam logic [5:0] OFF_MSK_SID_BASE = 6'h24;
	localparam logic [5:0] OFF_MSK_EID_BASE = 6'h28;
	localparam logic [5:0] OFF_END          = 6'h2b;

	// Standard identifier register layout
	localparam int SID_MSB  = 15;
	localparam int SID_LSB  = 5;
	localparam int TYPE_BIT = 3;
	localparam int EIDH_MSB = 1;
	localparam logic [15:0] SID_IMPL = 16'hffeb;

	localparam logic [15:0] BUF_PTR_RST = 16'h0000;
	localparam logic [15:0] MSK_SEL_RST = 16'h0000;
	localparam logic [15:0] FILT_EN_RST = 16'hffff;
	localparam logic [15:0] MASK_RST    = 16'h0000;
	localparam logic [15:0] ZERO16      = 16'h0000;

	localparam logic [3:0] BUF_FIFO     = 4'hf;
	localparam logic [1:0] MSEL_RSVD    = 2'h3;
	localparam logic [1:0] MSEL_MASK0   = 2'h0;
	localparam int         FIRST_PTR_FILT = 12;
	localparam int         NUM_MSEL_FILT  = 8;
	localparam int         NUM_MASKS      = 3;
endpackage

// ---- logic/cafm_filter_cmp.sv ----
// One acceptance filter comparator
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_cmp (
	input  wire logic        core_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        enable_in,
	input  wire logic [1:0]  mask_sel_in,
	input  wire logic [15:0] filt_sid_in,
	input  wire logic [15:0] filt_eid_in,
	input  wire logic [15:0] mask_sid_in,
	input  wire logic [15:0] mask_eid_in,
	input  wire logic        msg_ext_in,
	input  wire logic [10:0] msg_sid_in,
	input  wire logic [17:0] msg_eid_in,
	output logic             match_out
);
	logic sid_ok;
	logic eidh_ok;
	logic eidl_ok;
	logic type_ok;

	always_comb begin
		sid_ok = ((filt_sid_in[cafm_pkg::SID_MSB:cafm_pkg::SID_LSB] ^ msg_sid_in)
			& mask_sid_in[cafm_pkg::SID_MSB:cafm_pkg::SID_LSB]) == 11'h000;
		// extended bits 17:16, only for extended messages
		eidh_ok = !msg_ext_in || (((filt_sid_in[cafm_pkg::EIDH_MSB:0] ^ msg_eid_in[17:16])
			& mask_sid_in[cafm_pkg::EIDH_MSB:0]) == 2'h0);
		eidl_ok = !msg_ext_in || (((filt_eid_in ^ msg_eid_in[15:0]) & mask_eid_in)
			== cafm_pkg::ZERO16);
		// type select only counts when qualifier set
		type_ok = !mask_sid_in[cafm_pkg::TYPE_BIT]
			|| (filt_sid_in[cafm_pkg::TYPE_BIT] == msg_ext_in);
		// disabled filter or reserved mask never hits
		match_out = enable_in && (mask_sel_in != cafm_pkg::MSEL_RSVD)
			&& sid_ok && eidh_ok && eidl_ok && type_ok;
	end

	chk_sid_equal: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		match_out |-> ((filt_sid_in[15:5] & mask_sid_in[15:5])
		== (msg_sid_in & mask_sid_in[15:5])))
		else $error("standard identifier mismatch on hit");
	chk_type_qual: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(match_out && mask_sid_in[3]) |-> (filt_sid_in[3] == msg_ext_in))
		else $error("identifier type mismatch on hit");
	chk_eid_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(match_out && msg_ext_in) |-> ((filt_sid_in[1:0] & mask_sid_in[1:0])
		== (msg_eid_in[17:16] & mask_sid_in[1:0])))
		else $error("extended high bits mismatch on hit");
	chk_eid_low: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(match_out && msg_ext_in) |-> ((filt_eid_in & mask_eid_in)
		== (msg_eid_in[15:0] & mask_eid_in)))
		else $error("extended low bits mismatch on hit");
endmodule
`default_nettype wire

// ---- logic/cafm_first_hit.sv ----
// Lowest-numbered hit picker
`timescale 1ns/1ns
`default_nettype none
module cafm_first_hit #(
	parameter int N = 16
) (
	input  wire logic [N-1:0]         hit_vec_in,
	output logic                      any_out,
	output logic [$clog2(N)-1:0]      idx_out
);
	initial begin
		if (N < 2) begin
			$error("cafm_first_hit needs N of at least 2");
		end
	end

	// Lower filter number wins when several hit
	always_comb begin
		any_out = |hit_vec_in;
		idx_out = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hit_vec_in[i]) begin
				idx_out = i[$clog2(N)-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/cafm_filter_match.sv ----
// Acceptance filter bank with register port and hit result
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_match #(
	parameter int FILTERS = 16
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [5:0]  addr_in,
	input  wire logic [15:0] wr_data_in,
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	output logic      [15:0] rd_data_out,
	input  wire logic        msg_valid_in,
	input  wire logic        msg_ext_in,
	input  wire logic [10:0] msg_sid_in,
	input  wire logic [17:0] msg_eid_in,
	output logic             hit_valid_out,
	output logic             hit_out,
	output logic      [3:0]  hit_filter_out,
	output logic      [1:0]  hit_mask_out,
	output logic      [3:0]  hit_buffer_out,
	output logic             hit_fifo_out
);
	// Register layout packs exactly sixteen filters
	initial begin
		if (FILTERS != 16) begin
			$error("cafm_filter_match supports exactly 16 filters");
		end
	end

	logic [15:0] sid_ff [FILTERS];
	logic [15:0] nxt_sid [FILTERS];
	logic [15:0] eid_ff [FILTERS];
	logic [15:0] nxt_eid [FILTERS];
	logic [15:0] msk_sid_ff [cafm_pkg::NUM_MASKS];
	logic [15:0] nxt_msk_sid [cafm_pkg::NUM_MASKS];
	logic [15:0] msk_eid_ff [cafm_pkg::NUM_MASKS];
	logic [15:0] nxt_msk_eid [cafm_pkg::NUM_MASKS];
	logic [15:0] buf_ptr_ff;
	logic [15:0] nxt_buf_ptr;
	logic [15:0] msk_sel_ff;
	logic [15:0] nxt_msk_sel;
	logic [15:0] filt_en_ff;
	logic [15:0] nxt_filt_en;
	logic [15:0] rd_data_ff;
	logic [15:0] nxt_rd_data;
	logic        hit_valid_ff;
	logic        nxt_hit_valid;
	logic        hit_ff;
	logic        nxt_hit;
	logic [3:0]  hit_filter_ff;
	logic [3:0]  nxt_hit_filter;
	logic [1:0]  hit_mask_ff;
	logic [1:0]  nxt_hit_mask;
	logic [3:0]  hit_buffer_ff;
	logic [3:0]  nxt_hit_buffer;
	logic        hit_fifo_ff;
	logic        nxt_hit_fifo;

	logic [FILTERS-1:0] match_vec;
	logic [FILTERS-1:0] rsvd_vec;
	logic [1:0]         msel_of [FILTERS];
	logic [3:0]         dest_of [FILTERS];
	logic               any_hit;
	logic [3:0]         first_idx;
	logic [1:0]         msk_idx;
	logic [3:0]         reg_idx;

	// Register writes
	always_comb begin
		nxt_sid     = sid_ff;
		nxt_eid     = eid_ff;
		nxt_msk_sid = msk_sid_ff;
		nxt_msk_eid = msk_eid_ff;
		nxt_buf_ptr = buf_ptr_ff;
		nxt_msk_sel = msk_sel_ff;
		nxt_filt_en = filt_en_ff;
		reg_idx     = addr_in[3:0];
		msk_idx     = addr_in[1:0];
		if (wr_en_in) begin
			if (addr_in < cafm_pkg::OFF_EID_BASE) begin
				nxt_sid[reg_idx] = wr_data_in & cafm_pkg::SID_IMPL;
			end else if (addr_in < cafm_pkg::OFF_BUF_PTR) begin
				nxt_eid[reg_idx] = wr_data_in;
			end else if (addr_in == cafm_pkg::OFF_BUF_PTR) begin
				nxt_buf_ptr = wr_data_in;
			end else if (addr_in == cafm_pkg::OFF_MSK_SEL) begin
				nxt_msk_sel = wr_data_in;
			end else if (addr_in == cafm_pkg::OFF_FILT_EN) begin
				nxt_filt_en = wr_data_in;
			end else if ((addr_in >= cafm_pkg::OFF_MSK_SID_BASE)
				&& (addr_in < cafm_pkg::OFF_MSK_EID_BASE - 6'h01)) begin
				nxt_msk_sid[msk_idx] = wr_data_in & cafm_pkg::SID_IMPL;
			end else if ((addr_in >= cafm_pkg::OFF_MSK_EID_BASE)
				&& (addr_in < cafm_pkg::OFF_END)) begin
				nxt_msk_eid[msk_idx] = wr_data_in;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		sid_ff <= nxt_sid;
		eid_ff <= nxt_eid;
	end

	// control registers reset to known values
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buf_ptr_ff <= cafm_pkg::BUF_PTR_RST;
			msk_sel_ff <= cafm_pkg::MSK_SEL_RST;
			filt_en_ff <= cafm_pkg::FILT_EN_RST;
			for (int m = 0; m < cafm_pkg::NUM_MASKS; m++) begin
				msk_sid_ff[m] <= cafm_pkg::MASK_RST;
				msk_eid_ff[m] <= cafm_pkg::MASK_RST;
			end
		end else begin
			buf_ptr_ff <= nxt_buf_ptr;
			msk_sel_ff <= nxt_msk_sel;
			filt_en_ff <= nxt_filt_en;
			msk_sid_ff <= nxt_msk_sid;
			msk_eid_ff <= nxt_msk_eid;
		end
	end

	// Register reads, data valid for one cycle only
	always_comb begin
		nxt_rd_data = cafm_pkg::ZERO16;
		if (rd_en_in) begin
			if (addr_in < cafm_pkg::OFF_EID_BASE) begin
				// bits 4 and 2 read zero
				nxt_rd_data = sid_ff[reg_idx] & cafm_pkg::SID_IMPL;
			end else if (addr_in < cafm_pkg::OFF_BUF_PTR) begin
				nxt_rd_data = eid_ff[reg_idx];
			end else if (addr_in == cafm_pkg::OFF_BUF_PTR) begin
				nxt_rd_data = buf_ptr_ff;
			end else if (addr_in == cafm_pkg::OFF_MSK_SEL) begin
				nxt_rd_data = msk_sel_ff;
			end else if (addr_in == cafm_pkg::OFF_FILT_EN) begin
				nxt_rd_data = filt_en_ff;
			end else if (addr_in == cafm_pkg::OFF_HIT_STAT) begin
				nxt_rd_data = {hit_ff, hit_fifo_ff, hit_mask_ff, hit_buffer_ff,
					4'h0, hit_filter_ff};
			end else if ((addr_in >= cafm_pkg::OFF_MSK_SID_BASE)
				&& (addr_in < cafm_pkg::OFF_MSK_EID_BASE - 6'h01)) begin
				nxt_rd_data = msk_sid_ff[msk_idx] & cafm_pkg::SID_IMPL;
			end else if ((addr_in >= cafm_pkg::OFF_MSK_EID_BASE)
				&& (addr_in < cafm_pkg::OFF_END)) begin
				nxt_rd_data = msk_eid_ff[msk_idx];
			end
		end
	end

	// Filter bank
	for (genvar k = 0; k < FILTERS; k++) begin : g_filt
		if (k < cafm_pkg::NUM_MSEL_FILT) begin : g_msel
			// two bits per filter, filter 7 on top
			assign msel_of[k] = msk_sel_ff[2*k+1:2*k];
		end else begin : g_mask0
			assign msel_of[k] = cafm_pkg::MSEL_MASK0;
		end
		if (k >= cafm_pkg::FIRST_PTR_FILT) begin : g_ptr
			assign dest_of[k] = buf_ptr_ff[4*(k-cafm_pkg::FIRST_PTR_FILT)+:4];
		end else begin : g_self
			assign dest_of[k] = 4'(k);
		end
		assign rsvd_vec[k] = (msel_of[k] == cafm_pkg::MSEL_RSVD);

		cafm_filter_cmp u_cmp (
			.core_clk_in (core_clk_in),
			.rst_b_in    (rst_b_in),
			.enable_in   (filt_en_ff[k]),
			.mask_sel_in (msel_of[k]),
			.filt_sid_in (sid_ff[k]),
			.filt_eid_in (eid_ff[k]),
			.mask_sid_in (msk_sid_ff[msel_of[k]]),
			.mask_eid_in (msk_eid_ff[msel_of[k]]),
			.msg_ext_in  (msg_ext_in),
			.msg_sid_in  (msg_sid_in),
			.msg_eid_in  (msg_eid_in),
			.match_out   (match_vec[k])
		);
	end

	cafm_first_hit #(
		.N (FILTERS)
	) u_first (
		.hit_vec_in (match_vec),
		.any_out    (any_hit),
		.idx_out    (first_idx)
	);

	// Result captured one cycle after the identifier
	always_comb begin
		nxt_hit_valid  = msg_valid_in;
		nxt_hit        = hit_ff;
		nxt_hit_filter = hit_filter_ff;
		nxt_hit_mask   = hit_mask_ff;
		nxt_hit_buffer = hit_buffer_ff;
		nxt_hit_fifo   = hit_fifo_ff;
		if (msg_valid_in) begin
			nxt_hit        = any_hit;
			nxt_hit_filter = first_idx;
			nxt_hit_mask   = msel_of[first_idx];
			nxt_hit_buffer = dest_of[first_idx];
			// all-ones pointer routes to the FIFO
			nxt_hit_fifo   = any_hit && (first_idx >= 4'(cafm_pkg::FIRST_PTR_FILT))
				&& (dest_of[first_idx] == cafm_pkg::BUF_FIFO);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_ff    <= cafm_pkg::ZERO16;
			hit_valid_ff  <= 1'b0;
			hit_ff        <= 1'b0;
			hit_filter_ff <= 4'h0;
			hit_mask_ff   <= 2'h0;
			hit_buffer_ff <= 4'h0;
			hit_fifo_ff   <= 1'b0;
		end else begin
			rd_data_ff    <= nxt_rd_data;
			hit_valid_ff  <= nxt_hit_valid;
			hit_ff        <= nxt_hit;
			hit_filter_ff <= nxt_hit_filter;
			hit_mask_ff   <= nxt_hit_mask;
			hit_buffer_ff <= nxt_hit_buffer;
			hit_fifo_ff   <= nxt_hit_fifo;
		end
	end

	assign rd_data_out    = rd_data_ff;
	assign hit_valid_out  = hit_valid_ff;
	assign hit_out        = hit_ff;
	assign hit_filter_out = hit_filter_ff;
	assign hit_mask_out   = hit_mask_ff;
	assign hit_buffer_out = hit_buffer_ff;
	assign hit_fifo_out   = hit_fifo_ff;

	chk_bp_readback: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(rd_en_in && addr_in == cafm_pkg::OFF_BUF_PTR) |=> rd_data_out == $past(buf_ptr_ff))
		else $error("buffer pointer readback wrong");
	chk_msel_readback: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(rd_en_in && addr_in == cafm_pkg::OFF_MSK_SEL) |=> rd_data_out == $past(msk_sel_ff))
		else $error("mask select readback wrong");
	chk_sid_rsvd: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(rd_en_in && addr_in < cafm_pkg::OFF_EID_BASE) |=> (rd_data_out[4] == 1'b0
		&& rd_data_out[2] == 1'b0))
		else $error("unimplemented identifier bits read nonzero");
	chk_hit_enable: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(match_vec & ~filt_en_ff) == '0)
		else $error("disabled filter reported a match");
	chk_rsvd_mask: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(match_vec & rsvd_vec) == '0)
		else $error("filter with reserved mask select matched");
	chk_fifo_route: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		hit_fifo_out |-> (hit_out && hit_buffer_out == cafm_pkg::BUF_FIFO
		&& hit_filter_out[3:2] == 2'h3))
		else $error("FIFO routing without all-ones pointer");
	chk_hit_latency: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		msg_valid_in |=> (hit_valid_out && hit_out == $past(any_hit)))
		else $error("hit result not one cycle after identifier");
	chk_no_spurious: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!msg_valid_in |=> !hit_valid_out)
		else $error("hit result without identifier");

	// Routing checks rebuild each field from the raw registers
	chk_ptr_dest: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(msg_valid_in && any_hit && first_idx[3:2] == 2'h3)
		|=> hit_buffer_out == $past(buf_ptr_ff[{first_idx[1:0], 2'h0} +: 4]))
		else $error("pointer filter routed to wrong buffer");
	chk_msel_route: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(msg_valid_in && any_hit && !first_idx[3])
		|=> hit_mask_out == $past(msk_sel_ff[{first_idx[2:0], 1'b0} +: 2]))
		else $error("hit reports wrong mask source");
	chk_fifo_only: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(msg_valid_in && !(any_hit && first_idx[3:2] == 2'h3))
		|=> !hit_fifo_out)
		else $error("FIFO routing without pointer filter hit");
	chk_sid_store: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		(wr_en_in && addr_in < cafm_pkg::OFF_EID_BASE)
		|=> (sid_ff[$past(reg_idx)] & ~cafm_pkg::SID_IMPL) == cafm_pkg::ZERO16)
		else $error("unimplemented identifier bits stored");
	chk_rd_idle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!rd_en_in |=> rd_data_out == cafm_pkg::ZERO16)
		else $error("read data outside the read cycle");

	cov_fifo_hit: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		hit_valid_out && hit_fifo_out);
	cov_buffer_hit: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		hit_valid_out && hit_out && !hit_fifo_out);
	cov_miss: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		hit_valid_out && !hit_out);
	cov_ext_msg: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		msg_valid_in && msg_ext_in ##1 hit_out);
	cov_two_hits: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		msg_valid_in && !$onehot0(match_vec));
endmodule
`default_nettype wire

// ---- verif/cafm_rx_model.sv ----
// Receive path model that hands decoded identifiers to the filter bank
`timescale 1ns/1ns
`default_nettype none
module cafm_rx_model (
	input  wire logic        core_clk_in,
	output logic             msg_valid_out,
	output logic             msg_ext_out,
	output logic      [10:0] msg_sid_out,
	output logic      [17:0] msg_eid_out
);
	initial begin
		msg_valid_out = 1'b0;
		msg_ext_out = 1'b0;
		msg_sid_out = 11'h000;
		msg_eid_out = 18'h00000;
	end

	// One identifier per call; idle lines show the inverse so stale values never pass
	task automatic send(input logic ext, input logic [10:0] standard_identifier_bits, input logic [17:0] extended_identifier_bits);
		@(posedge core_clk_in);
		msg_valid_out <= 1'b1;
		msg_ext_out <= ext;
		msg_sid_out <= standard_identifier_bits;
		msg_eid_out <= extended_identifier_bits;
		@(posedge core_clk_in);
		msg_valid_out <= 1'b0;
		msg_ext_out <= ~ext;
		msg_sid_out <= ~standard_identifier_bits;
		msg_eid_out <= ~extended_identifier_bits;
	endtask
endmodule
`default_nettype wire

// ---- verif/cafm_filter_match_tb_top.sv ----
// Register and match tests for the acceptance filter bank
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_match_tb_top;
	logic        core_clk_in;
	logic        rst_b_in;
	logic [5:0]  addr_in;
	logic [15:0] wr_data_in;
	logic        wr_en_in;
	logic        rd_en_in;
	logic [15:0] rd_data_out;
	logic        msg_valid;
	logic        msg_ext;
	logic [10:0] msg_sid;
	logic [17:0] msg_eid;
	logic        hit_valid_out;
	logic        hit_out;
	logic [3:0]  hit_filter_out;
	logic [1:0]  hit_mask_out;
	logic [3:0]  hit_buffer_out;
	logic        hit_fifo_out;
	int          n_mismatch = 0;
	int          comparisons = 0;

	cafm_filter_match DUT (
		.core_clk_in   (core_clk_in),
		.rst_b_in      (rst_b_in),
		.addr_in       (addr_in),
		.wr_data_in    (wr_data_in),
		.wr_en_in      (wr_en_in),
		.rd_en_in      (rd_en_in),
		.rd_data_out   (rd_data_out),
		.msg_valid_in  (msg_valid),
		.msg_ext_in    (msg_ext),
		.msg_sid_in    (msg_sid),
		.msg_eid_in    (msg_eid),
		.hit_valid_out (hit_valid_out),
		.hit_out       (hit_out),
		.hit_filter_out(hit_filter_out),
		.hit_mask_out  (hit_mask_out),
		.hit_buffer_out(hit_buffer_out),
		.hit_fifo_out  (hit_fifo_out)
	);

	cafm_rx_model rx_model (
		.core_clk_in  (core_clk_in),
		.msg_valid_out(msg_valid),
		.msg_ext_out  (msg_ext),
		.msg_sid_out  (msg_sid),
		.msg_eid_out  (msg_eid)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge core_clk_in);
		wr_en_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		@(posedge core_clk_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_en_in <= 1'b0;
		#1;
		check("rd_data", rd_data_out, exp);
	endtask

	task automatic msg(input logic ext, input logic [10:0] standard_identifier_bits, input logic [17:0] extended_identifier_bits,
			input logic h, input logic [3:0] f, input logic [1:0] m, input logic [3:0] b,
			input logic fi);
		rx_model.send(ext, standard_identifier_bits, extended_identifier_bits);
		#1;
		check("hit_valid", {15'h0000, hit_valid_out}, 16'h0001);
		check("hit", {15'h0000, hit_out}, {15'h0000, h});
		check("hit_fifo", {15'h0000, hit_fifo_out}, {15'h0000, fi});
		if (h) begin
			check("hit_filter", {12'h000, hit_filter_out}, {12'h000, f});
			check("hit_mask", {14'h0000, hit_mask_out}, {14'h0000, m});
			check("hit_buffer", {12'h000, hit_buffer_out}, {12'h000, b});
		end
	endtask

	initial begin
		repeat (5000) @(posedge core_clk_in);
		n_mismatch++;
		final_report();
	end

	initial begin
		rst_b_in = 1'b0;
		addr_in = 6'h00;
		wr_data_in = 16'h0000;
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
		repeat (10) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		rd(6'h20, 16'h0000);
		rd(6'h21, 16'h0000);
		rd(6'h22, 16'hffff);
		// Unmapped and read-only places keep nothing
		wr(6'h2b, 16'hffff);
		rd(6'h2b, 16'h0000);
		wr(6'h27, 16'hffff);
		rd(6'h27, 16'h0000);
		wr(6'h23, 16'hffff);
		rd(6'h23, 16'h0000);
		wr(6'h0f, 16'hffff);
		rd(6'h0f, 16'hffeb);
		wr(6'h1f, 16'h5a5a);
		rd(6'h1f, 16'h5a5a);
		wr(6'h20, 16'ha5c3);
		rd(6'h20, 16'ha5c3);
		wr(6'h21, 16'he4c3);
		rd(6'h21, 16'he4c3);
		// Identifier registers are not reset, so every filter is cleared first
		for (int n = 0; n < 16; n++) begin
			wr(6'(n), 16'h0000);
			wr(6'h10 + 6'(n), 16'h0000);
		end
		rd(6'h07, 16'h0000);
		wr(6'h21, 16'h0000);
		wr(6'h24, 16'hffeb);
		wr(6'h28, 16'hffff);
		wr(6'h03, 16'hb4aa);
		wr(6'h13, 16'h1234);
		rd(6'h03, 16'hb4aa);
		wr(6'h22, 16'h0008);
		msg(1'b1, 11'h5a5, 18'h21234, 1'b1, 4'h3, 2'h0, 4'h3, 1'b0);
		msg(1'b1, 11'h5a4, 18'h21234, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		msg(1'b1, 11'h5a5, 18'h01234, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		msg(1'b1, 11'h5a5, 18'h21235, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		msg(1'b0, 11'h5a5, 18'h21234, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		wr(6'h24, 16'hffe3);
		msg(1'b0, 11'h5a5, 18'h3ffff, 1'b1, 4'h3, 2'h0, 4'h3, 1'b0);
		wr(6'h22, 16'h0000);
		msg(1'b1, 11'h5a5, 18'h21234, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		// Filter 1 through mask sources 1, 3 (reserved) and 2
		wr(6'h21, 16'h0004);
		wr(6'h22, 16'h0002);
		msg(1'b1, 11'h7ff, 18'h3ffff, 1'b1, 4'h1, 2'h1, 4'h1, 1'b0);
		wr(6'h21, 16'h000c);
		msg(1'b1, 11'h7ff, 18'h3ffff, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		wr(6'h21, 16'h0008);
		wr(6'h26, 16'hffe3);
		rd(6'h26, 16'hffe3);
		msg(1'b0, 11'h001, 18'h00000, 1'b0, 4'h0, 2'h0, 4'h0, 1'b0);
		msg(1'b0, 11'h000, 18'h3ffff, 1'b1, 4'h1, 2'h2, 4'h1, 1'b0);
		// Two hits at once: the lower filter and its pointer win
		wr(6'h20, 16'h00f7);
		wr(6'h22, 16'h3000);
		msg(1'b0, 11'h000, 18'h00000, 1'b1, 4'hc, 2'h0, 4'h7, 1'b0);
		wr(6'h22, 16'h2000);
		msg(1'b0, 11'h000, 18'h00000, 1'b1, 4'hd, 2'h0, 4'hf, 1'b1);
		rd(6'h23, 16'hcf0d);
		// Reset in mid-run must restore every control register
		@(posedge core_clk_in);
		rst_b_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		rd(6'h20, 16'h0000);
		rd(6'h21, 16'h0000);
		rd(6'h22, 16'hffff);
		rd(6'h24, 16'h0000);
		rd(6'h23, 16'h0000);
		// All masks clear: nothing compared, lowest filter wins
		msg(1'b0, 11'h7ff, 18'h3ffff, 1'b1, 4'h0, 2'h0, 4'h0, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
